// >>> hw/arsc_defs.svh
// register offsets, field positions, reset values and timing constants in ns of the ADC read sequencer control
// assumes a 40 MHz CLOCK; included by bare name
`ifndef ARSC_DEFS_SVH
`define ARSC_DEFS_SVH

`define ARSC_OFF_CTRL      6'h2B
`define ARSC_OFF_DELAY     6'h2C
`define ARSC_OFF_SEL_A     6'h2D
`define ARSC_OFF_SEL_B     6'h2E
`define ARSC_OFF_RES_FIRST 6'h2F
`define ARSC_OFF_RES_LAST  6'h32

`define ARSC_BIT_GEN_START   1
`define ARSC_BIT_TOUCH_START 13
`define ARSC_RES_EVEN_LSB    2
`define ARSC_RES_ODD_LSB     14
`define ARSC_SELB_TOUCH_LSB  8

`define ARSC_REG_RESET  24'h000000
`define ARSC_RES_RESET  10'h000

`define ARSC_CLK_PERIOD_NS 25
`define ARSC_DLY_UNIT_NS   1000

`endif

// >>> hw/arsc_pkg.sv
// types of the ADC read sequencer control
// assumes nothing of its surroundings
package arsc_pkg;

	typedef struct packed {
		logic [2:0] spare_hi;
		logic       pen_detect_enable;
		logic       spare_19;
		logic [2:0] touch_last_slot;
		logic       touch_hold;
		logic       touch_continuous;
		logic       touch_seq_start_req;
		logic       touch_power_enable;
		logic [2:0] spare_mid;
		logic       manual_led_select;
		logic       spare_7;
		logic [2:0] general_last_slot;
		logic       general_hold;
		logic       general_continuous;
		logic       general_seq_start_req;
		logic       converter_power_enable;
	} arsc_ctrl_t;

	typedef struct packed {
		logic [3:0] post_set_delay;
		logic [3:0] inter_reading_delay;
		logic [3:0] pre_set_delay;
	} arsc_dly_t;

	typedef enum logic [1:0] {
		ARSC_ACT_DUMMY   = 2'b00,
		ARSC_ACT_XPLATE  = 2'b01,
		ARSC_ACT_YPLATE  = 2'b10,
		ARSC_ACT_CONTACT = 2'b11
	} arsc_touch_act_t;

	typedef enum logic [2:0] {
		ARSC_IDLE = 3'b000,
		ARSC_PRE  = 3'b001,
		ARSC_CONV = 3'b010,
		ARSC_WAIT = 3'b011,
		ARSC_GAP  = 3'b100,
		ARSC_POST = 3'b101
	} arsc_state_t;

	typedef struct packed {
		logic            touch;
		logic [3:0]      channel;
		arsc_touch_act_t action;
	} arsc_conv_t;

endpackage

// >>> hw/arsc_result_mem.sv
// slot result memory: one write port, two read ports with registered data
// assumes a synchronous active-high reset that clears every word
`include "arsc_defs.svh"

module arsc_result_mem #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr_a,
	input  wire logic [AW-1:0]    rd_addr_b,
	output logic      [WIDTH-1:0] rd_data_a,
	output logic      [WIDTH-1:0] rd_data_b
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= WIDTH'(`ARSC_RES_RESET);
			end
		end else if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_a <= '0;
			rd_data_b <= '0;
		end else begin
			rd_data_a <= mem_q[rd_addr_a];
			rd_data_b <= mem_q[rd_addr_b];
		end
	end

endmodule // arsc_result_mem

// >>> hw/arsc_seq_ctrl.sv
// ADC read sequencer control: register file, sequencer and converter handshake
// assumes a parallel register port behind the serial interface and an analog converter whose
// done strobe and result arrive from outside the clock domain
`include "arsc_defs.svh"

module arsc_seq_ctrl #(
	parameter int DLY_UNIT_CYCLES = `ARSC_DLY_UNIT_NS / `ARSC_CLK_PERIOD_NS,
	parameter int SLOTS           = 8
) (
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic [5:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [23:0] REG_WDATA,
	output logic      [23:0] REG_RDATA,
	output logic             REG_RVALID,
	output logic             CONV_POWER_EN,
	output logic             TOUCH_POWER_EN,
	output logic             PEN_DETECT_EN,
	output logic             MANUAL_LED_EN,
	output logic             CONV_START,
	output logic      [3:0]  CONV_CHANNEL,
	output logic             CONV_TOUCH,
	output logic      [1:0]  CONV_TOUCH_ACTION,
	input  wire logic        CONV_DONE,
	input  wire logic [9:0]  CONV_RESULT,
	output logic             SEQ_BUSY
);

	arsc_pkg::arsc_ctrl_t  ctrl_q, ctrl_d;
	arsc_pkg::arsc_state_t state_q;
	arsc_pkg::arsc_conv_t  conv_q;
	logic [23:0] dly_q, sela_q, selb_q;
	logic        run_touch_q, got_q;
	logic [2:0]  slot_q;
	logic [15:0] cnt_q;
	logic [9:0]  res_q;
	logic        done_s1_q, done_s2_q, done_s3_q;
	logic [9:0]  data_s1_q, data_s2_q;
	logic        done_rise, hold_act, cont_act, end_of_set, mem_we;
	logic        take_touch, take_gen;
	logic [2:0]  last_slot;
	arsc_pkg::arsc_dly_t dly_act;
	logic        wr_ctrl, rd_q;
	logic [5:0]  rd_addr_q;
	logic [2:0]  rd_pair;
	logic [9:0]  rd_even, rd_odd;

	function automatic logic [3:0] chan_of(input logic [2:0] s, input logic [23:0] a, input logic [23:0] b);
		logic [31:0] all;
		all = {b[7:0], a};
		return all[{s, 2'b00} +: 4];
	endfunction

	function automatic logic [1:0] act_of(input logic [2:0] s, input logic [23:0] b);
		logic [15:0] acts;
		acts = b[23:`ARSC_SELB_TOUCH_LSB];
		return acts[{s, 1'b0} +: 2];
	endfunction

	function automatic logic [15:0] dly_cycles(input logic [3:0] f);
		return 16'(f) * 16'(DLY_UNIT_CYCLES);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// register file

	assign wr_ctrl = REG_WR && (REG_ADDR == `ARSC_OFF_CTRL);

	always_comb begin
		ctrl_d = wr_ctrl ? arsc_pkg::arsc_ctrl_t'(REG_WDATA) : ctrl_q;
		// hardware clears a taken request; a write of one in the same cycle survives
		if (take_gen && !(wr_ctrl && REG_WDATA[`ARSC_BIT_GEN_START])) begin
			ctrl_d.general_seq_start_req = 1'b0;
		end
		if (take_touch && !(wr_ctrl && REG_WDATA[`ARSC_BIT_TOUCH_START])) begin
			ctrl_d.touch_seq_start_req = 1'b0;
		end
		// continuous mode re-arms its own request, winning over a write of zero
		if (end_of_set && cont_act && !run_touch_q) begin
			ctrl_d.general_seq_start_req = 1'b1;
		end
		if (end_of_set && cont_act && run_touch_q) begin
			ctrl_d.touch_seq_start_req = 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ctrl_q <= arsc_pkg::arsc_ctrl_t'(`ARSC_REG_RESET);
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			dly_q  <= `ARSC_REG_RESET;
			sela_q <= `ARSC_REG_RESET;
			selb_q <= `ARSC_REG_RESET;
		end else if (REG_WR) begin
			if (REG_ADDR == `ARSC_OFF_DELAY) dly_q <= REG_WDATA;
			if (REG_ADDR == `ARSC_OFF_SEL_A) sela_q <= REG_WDATA;
			if (REG_ADDR == `ARSC_OFF_SEL_B) selb_q <= REG_WDATA;
		end
	end

	assign CONV_POWER_EN  = ctrl_q.converter_power_enable;
	assign TOUCH_POWER_EN = ctrl_q.touch_power_enable;
	assign PEN_DETECT_EN  = ctrl_q.pen_detect_enable;
	assign MANUAL_LED_EN  = ctrl_q.manual_led_select;

	////////////////////////////////////////////////////////////////////////////////
	// read path: two cycles, results paired two slots per word

	assign rd_pair = 3'(REG_ADDR - `ARSC_OFF_RES_FIRST);

	arsc_result_mem #(.WIDTH(10), .DEPTH(SLOTS), .AW(3)) u_mem (
		.clk       (CLOCK),
		.rst       (RST),
		.wr_en     (mem_we),
		.wr_addr   (slot_q),
		.wr_data   (res_q),
		.rd_addr_a ({rd_pair[1:0], 1'b0}),
		.rd_addr_b ({rd_pair[1:0], 1'b1}),
		.rd_data_a (rd_even),
		.rd_data_b (rd_odd)
	);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rd_q       <= 1'b0;
			rd_addr_q  <= 6'h00;
			REG_RVALID <= 1'b0;
			REG_RDATA  <= 24'h000000;
		end else begin
			rd_q       <= REG_RD;
			rd_addr_q  <= REG_ADDR;
			REG_RVALID <= rd_q;
			if (rd_q) begin
				if (rd_addr_q == `ARSC_OFF_CTRL) REG_RDATA <= ctrl_q;
				else if (rd_addr_q == `ARSC_OFF_DELAY) REG_RDATA <= dly_q;
				else if (rd_addr_q == `ARSC_OFF_SEL_A) REG_RDATA <= sela_q;
				else if (rd_addr_q == `ARSC_OFF_SEL_B) REG_RDATA <= selb_q;
				else if (rd_addr_q >= `ARSC_OFF_RES_FIRST && rd_addr_q <= `ARSC_OFF_RES_LAST)
					REG_RDATA <= {rd_odd, 2'b00, rd_even, 2'b00};
				else REG_RDATA <= 24'h000000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// converter done and result synchronisers

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
			data_s1_q <= 10'h000;
			data_s2_q <= 10'h000;
		end else begin
			done_s1_q <= CONV_DONE;
			done_s2_q <= done_s1_q;
			done_s3_q <= done_s2_q;
			data_s1_q <= CONV_RESULT;
			data_s2_q <= data_s1_q;
		end
	end

	assign done_rise = done_s2_q && !done_s3_q;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	assign hold_act   = run_touch_q ? ctrl_q.touch_hold : ctrl_q.general_hold;
	assign cont_act   = run_touch_q ? ctrl_q.touch_continuous : ctrl_q.general_continuous;
	assign last_slot  = run_touch_q ? ctrl_q.touch_last_slot : ctrl_q.general_last_slot;
	assign dly_act    = arsc_pkg::arsc_dly_t'(run_touch_q ? dly_q[23:12] : dly_q[11:0]);
	assign take_touch = (state_q == arsc_pkg::ARSC_IDLE) && ctrl_q.touch_seq_start_req
	                    && !ctrl_q.touch_hold;
	assign take_gen   = (state_q == arsc_pkg::ARSC_IDLE) && ctrl_q.general_seq_start_req
	                    && !ctrl_q.general_hold && !take_touch;
	assign mem_we     = (state_q == arsc_pkg::ARSC_WAIT) && got_q && !hold_act;
	assign end_of_set = mem_we && (slot_q == last_slot);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_q     <= arsc_pkg::ARSC_IDLE;
			run_touch_q <= 1'b0;
			slot_q      <= 3'h0;
			cnt_q       <= 16'h0000;
		end else begin
			unique case (state_q)
				arsc_pkg::ARSC_IDLE: begin
					if (take_touch || take_gen) begin
						run_touch_q <= take_touch;
						slot_q      <= 3'h0;
						cnt_q       <= dly_cycles(take_touch ? dly_q[15:12] : dly_q[3:0]);
						state_q     <= arsc_pkg::ARSC_PRE;
					end
				end
				arsc_pkg::ARSC_PRE, arsc_pkg::ARSC_GAP: begin
					if (!hold_act) begin
						if (cnt_q == 16'h0000) state_q <= arsc_pkg::ARSC_CONV;
						else cnt_q <= cnt_q - 16'h0001;
					end
				end
				arsc_pkg::ARSC_CONV: begin
					if (!hold_act) state_q <= arsc_pkg::ARSC_WAIT;
				end
				arsc_pkg::ARSC_WAIT: begin
					if (end_of_set) begin
						cnt_q   <= cont_act ? dly_cycles(dly_act.post_set_delay) : 16'h0000;
						state_q <= arsc_pkg::ARSC_POST;
					end else if (mem_we) begin
						slot_q  <= slot_q + 3'h1;
						cnt_q   <= dly_cycles(dly_act.inter_reading_delay);
						state_q <= arsc_pkg::ARSC_GAP;
					end
				end
				arsc_pkg::ARSC_POST: begin
					if (!hold_act) begin
						if (cnt_q == 16'h0000) state_q <= arsc_pkg::ARSC_IDLE;
						else cnt_q <= cnt_q - 16'h0001;
					end
				end
				default: state_q <= arsc_pkg::ARSC_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			got_q <= 1'b0;
			res_q <= 10'h000;
		end else if (mem_we) begin
			got_q <= 1'b0;
		end else if (state_q == arsc_pkg::ARSC_WAIT && done_rise && !got_q) begin
			got_q <= 1'b1;
			res_q <= data_s2_q;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			conv_q <= '0;
		end else begin
			conv_q.touch   <= run_touch_q;
			conv_q.channel <= chan_of(slot_q, sela_q, selb_q);
			conv_q.action  <= arsc_pkg::arsc_touch_act_t'(act_of(slot_q, selb_q));
		end
	end

	assign CONV_START        = (state_q == arsc_pkg::ARSC_CONV) && !hold_act;
	assign CONV_CHANNEL      = conv_q.channel;
	assign CONV_TOUCH        = conv_q.touch;
	assign CONV_TOUCH_ACTION = conv_q.action;
	assign SEQ_BUSY          = state_q != arsc_pkg::ARSC_IDLE;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	sequence s_idle_touch_req;
		state_q == arsc_pkg::ARSC_IDLE && ctrl_q.touch_seq_start_req && !ctrl_q.touch_hold;
	endsequence

	sequence s_last_written;
		state_q == arsc_pkg::ARSC_WAIT && got_q && !hold_act && slot_q == last_slot;
	endsequence

	a_touch_first_taken: assert property (s_idle_touch_req |=> state_q == arsc_pkg::ARSC_PRE && run_touch_q)
		else $error("touch request not served first");
	a_gen_start_taken: assert property (state_q == arsc_pkg::ARSC_IDLE && ctrl_q.general_seq_start_req
		&& !ctrl_q.general_hold && !ctrl_q.touch_seq_start_req |=> state_q == arsc_pkg::ARSC_PRE && !run_touch_q)
		else $error("general request not started");
	a_run_from_zero: assert property (state_q == arsc_pkg::ARSC_IDLE ##1 state_q == arsc_pkg::ARSC_PRE
		|-> slot_q == 3'h0)
		else $error("sequence did not start at slot zero");
	a_hold_freezes: assert property (state_q != arsc_pkg::ARSC_IDLE && hold_act
		|-> !mem_we ##1 ($stable(state_q) && $stable(slot_q)))
		else $error("sequencer moved while held");
	a_last_slot_ends: assert property (s_last_written |=> state_q == arsc_pkg::ARSC_POST)
		else $error("set did not end at last slot");
	a_cont_rearms: assert property (s_last_written and cont_act
		|=> (run_touch_q ? ctrl_q.touch_seq_start_req : ctrl_q.general_seq_start_req))
		else $error("continuous mode did not re-arm");
	a_single_stops: assert property (s_last_written and !cont_act
		|=> state_q == arsc_pkg::ARSC_POST ##1 (hold_act || state_q == arsc_pkg::ARSC_IDLE))
		else $error("single run did not stop");
	a_gen_stays_pending: assert property (SEQ_BUSY && run_touch_q && ctrl_q.general_seq_start_req && !wr_ctrl
		|=> ctrl_q.general_seq_start_req)
		else $error("general request lost during touch run");
	a_write_after_done: assert property (state_q == arsc_pkg::ARSC_WAIT && done_rise && !got_q
		|=> got_q && res_q == $past(data_s2_q))
		else $error("conversion result not captured");
	a_gap_then_start: assert property (state_q == arsc_pkg::ARSC_GAP && cnt_q == 16'h0000 && !hold_act
		|=> state_q == arsc_pkg::ARSC_CONV)
		else $error("gap delay did not end in a conversion");

endmodule // arsc_seq_ctrl

// >>> testbench/arsc_conv_model.sv
// converter model: answers each start lim_q + 5 or more cycles after the last one taken with a done pulse and a result built from the slot selection
// assumes single-cycle start pulses sampled on the rising edge of clk
module arsc_conv_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       start,
	input  wire logic [3:0] channel,
	input  wire logic       touch,
	input  wire logic [1:0] action,
	input  wire logic [2:0] salt,
	input  wire logic       slow,
	output logic            done,
	output logic      [9:0] result
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned t_q;
	int unsigned lim_q;
	logic [9:0]  val_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			t_q <= 0;
			lim_q <= 0;
			val_q <= 10'h000;
		end else if (start && (t_q == 0 || t_q >= lim_q + 5)) begin
			t_q <= 1;
			lim_q <= slow ? 10 : 1;
			val_q <= {channel, touch, touch ? action : 2'b00, salt};
		end else if (t_q != 0) begin
			t_q <= (t_q >= lim_q + 8) ? 0 : t_q + 1;
		end
	end
	// outside its hold window the result line toggles, so a stale value never passes
	always_ff @(posedge clk) begin
		if (rst) begin
			done <= 1'b0;
			result <= 10'h2AA;
		end else begin
			done <= t_q > lim_q && t_q < lim_q + 5;
			result <= (t_q >= lim_q && t_q < lim_q + 8) ? val_q : ~result;
		end
	end
endmodule // arsc_conv_model

// >>> testbench/adc_read_sequencer_control_tb.sv
// bench of the ADC read sequencer control: register tasks, reference model, scenarios
// assumes the converter model and the design files are compiled first
module adc_read_sequencer_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [23:0] BASE = 24'h001001, GS = 24'h000002, GC = 24'h000004, GH = 24'h000008;
	localparam logic [23:0] TS = 24'h002000, TC = 24'h004000, TH = 24'h008000;
	logic        CLOCK = 0, RST = 1, REG_WR = 0, REG_RD = 0, REG_RVALID, CONV_START, CONV_TOUCH, CONV_DONE;
	logic        SEQ_BUSY, pwr_conv, pwr_touch, pen_en, led_en, slow = 0;
	logic [5:0]  REG_ADDR = 0;
	logic [23:0] REG_WDATA = 0, REG_RDATA, dly, rdv, c, h;
	logic [3:0]  CONV_CHANNEL, sel[8];
	logic [1:0]  CONV_TOUCH_ACTION, act[8];
	logic [9:0]  CONV_RESULT, res[8];
	logic [2:0]  salt = 0;
	logic [31:0] seed = 32'hD77E;
	logic [3:0]  q_ch[$];
	logic        q_t[$];
	logic [1:0]  q_act[$];
	int          q_cyc[$];
	int          miscompares = 0, checked = 0, cyc = 0, wcyc, w0, n, last;

	arsc_seq_ctrl #(.DLY_UNIT_CYCLES(1)) dut_u (.CLOCK(CLOCK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
		.CONV_POWER_EN(pwr_conv), .TOUCH_POWER_EN(pwr_touch), .PEN_DETECT_EN(pen_en), .MANUAL_LED_EN(led_en),
		.CONV_START(CONV_START), .CONV_CHANNEL(CONV_CHANNEL), .CONV_TOUCH(CONV_TOUCH),
		.CONV_TOUCH_ACTION(CONV_TOUCH_ACTION), .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT), .SEQ_BUSY(SEQ_BUSY));
	arsc_conv_model conv_u (.clk(CLOCK), .rst(RST), .start(CONV_START), .channel(CONV_CHANNEL), .touch(CONV_TOUCH),
		.action(CONV_TOUCH_ACTION), .salt(salt), .slow(slow), .done(CONV_DONE), .result(CONV_RESULT));

	initial begin
		forever #12.5 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (RST === 1'b0 && CONV_START === 1'b1) begin
			q_ch.push_back(CONV_CHANNEL);
			q_t.push_back(CONV_TOUCH);
			q_act.push_back(CONV_TOUCH_ACTION);
			q_cyc.push_back(cyc);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	function logic [31:0] lfsr();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
		return seed;
	endfunction
	task chk_rd(input string nm, input logic [23:0] e, input logic [23:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_out(input string nm, input logic [9:0] e, input logic [9:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task wr(input logic [5:0] a, input logic [23:0] d);
		@(negedge CLOCK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		wcyc = cyc;
		@(negedge CLOCK);
		REG_WR = 1'b0;
	endtask
	task rd(input logic [5:0] a, output logic [23:0] d);
		int k;
		@(negedge CLOCK);
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(negedge CLOCK);
		REG_RD = 1'b0;
		for (k = 0; k < 4 && REG_RVALID !== 1'b1; k++) @(negedge CLOCK);
		if (k == 4) begin
			miscompares++;
			final_report();
		end
		d = REG_RDATA;
	endtask
	task wait_idle;
		int quiet, k;
		quiet = 0;
		for (k = 0; k < 3000 && quiet < 8; k++) begin
			@(negedge CLOCK);
			quiet = SEQ_BUSY === 1'b0 ? quiet + 1 : 0;
		end
		if (quiet < 8) begin
			miscompares++;
			final_report();
		end
	endtask
	task clr_q;
		q_ch.delete();
		q_t.delete();
		q_act.delete();
		q_cyc.delete();
	endtask
	// new delays, channels and actions, read back
	task setup;
		logic [23:0] a, b;
		dly = 24'(lfsr());
		a = 24'(lfsr());
		b = 24'(lfsr());
		salt = 3'(lfsr());
		slow = seed[7];
		wr(6'h2C, dly);
		wr(6'h2D, a);
		wr(6'h2E, b);
		for (int k = 0; k < 8; k++) begin
			sel[k] = k < 6 ? a[4*k +: 4] : b[4*(k-6) +: 4];
			act[k] = b[8+2*k +: 2];
		end
		rd(6'h2C, rdv);
		chk_rd("delay register", dly, rdv);
		rd(6'h2D, rdv);
		chk_rd("select register a", a, rdv);
		rd(6'h2E, rdv);
		chk_rd("select register b", b, rdv);
	endtask
	task model_run(input logic t, input int lst);
		for (int k = 0; k <= lst; k++) res[k] = {sel[k], t, t ? act[k] : 2'b00, salt};
	endtask
	// n1 slots of type ft come first, then n2 of the other type
	task check_seq(input logic ft, input int n1, input int n2);
		logic t;
		int ix;
		chk_out("slot count", 10'(n1 + n2), 10'(q_ch.size()));
		chk_out("pre delay", 10'(3 + (ft ? dly[15:12] : dly[3:0])), 10'(q_cyc[0] - w0));
		for (int k = 0; k < q_ch.size(); k++) begin
			t = k < n1 ? ft : !ft;
			ix = k < n1 ? k : k - n1;
			chk_out("sequence type", 10'(t), 10'(q_t[k]));
			if (t) chk_out("touch action", 10'(act[ix]), 10'(q_act[k]));
			else chk_out("channel", 10'(sel[ix]), 10'(q_ch[k]));
		end
		clr_q();
	endtask
	task check_all(input logic [23:0] ce);
		wr(6'h2F, 24'(lfsr()));
		rd(6'h2B, rdv);
		chk_rd("control", ce, rdv);
		for (int p = 0; p < 4; p++) begin
			rd(6'h2F + 6'(p), rdv);
			chk_rd("result word", {res[2*p+1], 2'b00, res[2*p], 2'b00}, rdv);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		foreach (res[k]) res[k] = 10'h000;
		repeat (6) @(negedge CLOCK);
		RST = 1'b0;
		check_all(24'h000000);
		for (int k = 0; k < 4; k++) begin
			c = 24'(lfsr()) & 24'h17D17D;
			if (c[20]) c[12] = 1'b0;
			wr(6'h2B, c);
			rd(6'h2B, rdv);
			chk_rd("control", c, rdv);
			chk_out("power and led", 10'({c[20], c[12], c[8], c[0]}), 10'({pen_en, pwr_touch, led_en, pwr_conv}));
		end
		wr(6'h2B, 24'h000000);
		rd(6'h00, rdv);
		chk_rd("unmapped", 24'h000000, rdv);
		for (int t = 0; t < 2; t++) begin
			setup();
			last = lfsr() % 8;
			c = t ? (BASE | TS | (24'(last) << 16)) : (BASE | GS | (24'(last) << 4));
			wr(6'h2B, c | (t ? TH : GH));
			repeat (20) @(negedge CLOCK);
			chk_out("starts under hold", 10'h000, 10'(q_ch.size()));
			wr(6'h2B, c);
			w0 = wcyc;
			wait_idle();
			model_run(t, last);
			check_seq(t, last + 1, 0);
			check_all(c & ~(GS | TS));
		end
		for (int m = 0; m < 2; m++) begin
			setup();
			c = BASE | GS | 24'h000010 | 24'h030000;
			if (m == 0) wr(6'h2B, c | TS);
			else begin
				wr(6'h2B, BASE | TS | 24'h030000);
				h = wcyc;
				repeat (4) @(negedge CLOCK);
				wr(6'h2B, c);
				wcyc = h;
			end
			w0 = wcyc;
			wait_idle();
			model_run(1, 3);
			model_run(0, 1);
			check_seq(1, 4, 2);
			check_all(c & ~GS);
		end
		for (int t = 0; t < 2; t++) begin
			setup();
			c = t ? (BASE | TS | TC | 24'h010000) : (BASE | GS | GC | 24'h000010);
			wr(6'h2B, c);
			for (n = 0; n < 600 && q_ch.size() < 6; n++) @(negedge CLOCK);
			chk_out("repeated slots", 10'h001, 10'(q_ch.size() >= 6));
			if (q_ch.size() < 6) final_report();
			// set-to-set gap minus in-set gap: converter latency cancels out
			n = 2 + (t ? dly[23:20] + dly[15:12] - dly[19:16] : dly[11:8] + dly[3:0] - dly[7:4]);
			chk_out("post delay", 10'(n), 10'(q_cyc[2] - 2 * q_cyc[1] + q_cyc[0]));
			wr(6'h2B, (c & ~(GS | TS)) | (t ? TH : GH));
			repeat (3) @(negedge CLOCK);
			n = q_ch.size();
			repeat (30) @(negedge CLOCK);
			chk_out("starts under hold", 10'(n), 10'(q_ch.size()));
			wr(6'h2B, BASE);
			wait_idle();
			clr_q();
		end
		final_report();
	end
endmodule // adc_read_sequencer_control_tb
